// ==== hw/nco_mode_and_output_control.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1: phase source select high loads phase offset from programmed phase input.
// RULE2: select low: PSK levels fill top three offset bits, lower 13 zero.
// RULE3: carry input is sampled on the clock before entering the accumulation.
// RULE4: active timer init loads timer increment and zeroes timer feedback.
// RULE5: test select routes the phase accumulator bus to the data outputs.
// RULE6: serial mode loads words while accumulator enable low, shifts after it rises.
// RULE7: parallel mode loads output registers every clock, with no shifting.
// RULE8: format low inverts sine and cosine MSB for offset binary.
// RULE9: sine bus driven only while its enable pin is low.
// RULE10: cosine bus driven only while its enable pin is low.
// RULE11: timer carry output goes low on a timer accumulator carry.
// RULE12: serial strobe pulses low with first bit; stays high in parallel.
// RULE13: serial sine word leaves top pin MSB first, bottom pin LSB first.
// RULE14: serial cosine word leaves top pin MSB first, bottom pin LSB first.
// RULE15: parallel mode presents full sixteen-bit sine and cosine words.
// RULE16: one simultaneous sine and cosine sample pair per clock.
// RULE17: phase accumulates from controls and converts to amplitude by lookup.
// RULE18: PSK levels give eight phases from zero to 315 degrees.
// RULE19: PSK levels captured only when offset register load is enabled.
// RULE20: controller drives accumulator enable low to advance; it frames serial loads.
// RULE21: each bus has its own output enable for the pad tristate.
module nco_mode_and_output_control (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PHASE_SOURCE_SELECT,
  input wire logic [nco_ctrl_pkg::PSK_W-1:0] PSK_LEVEL_INPUTS,
  input wire logic PHASE_CARRY_IN_N,
  input wire logic TIMER_ACCUM_INIT_N,
  input wire logic TEST_SELECT,
  input wire logic OUTPUT_PARALLEL_NOT_SERIAL,
  input wire logic OUTPUT_FORMAT_SELECT,
  input wire logic SINE_OUTPUT_ENABLE_N,
  input wire logic COSINE_OUTPUT_ENABLE_N,
  input wire logic PHASE_ACCUM_LOAD_EN_N,
  input wire logic PHASE_OFFSET_LOAD_EN_N,
  input wire logic [nco_ctrl_pkg::WORD_W-1:0] PHASE_INPUT,
  input wire logic [nco_ctrl_pkg::PHASE_W-1:0] FREQ_WORD,
  input wire logic [nco_ctrl_pkg::PHASE_W-1:0] TIMER_INCREMENT,
  output logic [nco_ctrl_pkg::WORD_W-1:0] SIN_OUT,
  output logic SIN_OUT_EN_N,
  output logic [nco_ctrl_pkg::WORD_W-1:0] COS_OUT,
  output logic COS_OUT_EN_N,
  output logic TIMER_CARRY_OUT_N,
  output logic CONVERTER_WORD_STROBE_N
);
  import nco_ctrl_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_reg, sync1_next;
  logic [SYNC_W-1:0] sync2_reg, sync2_next;

  assign pins = {PHASE_OFFSET_LOAD_EN_N, PHASE_ACCUM_LOAD_EN_N, COSINE_OUTPUT_ENABLE_N,
                 SINE_OUTPUT_ENABLE_N, OUTPUT_FORMAT_SELECT, OUTPUT_PARALLEL_NOT_SERIAL,
                 TEST_SELECT, TIMER_ACCUM_INIT_N, PHASE_CARRY_IN_N, PSK_LEVEL_INPUTS,
                 PHASE_SOURCE_SELECT};

  always_comb begin
    sync1_next = pins;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic psel_s, carry_s, tinit_s, test_s, par_s, fmt_s, accen_s, poen_s;
  logic [PSK_W-1:0] psk_s;

  assign psel_s = sync2_reg[SY_PSEL];
  assign psk_s = sync2_reg[SY_PSK_LO +: PSK_W];
  assign carry_s = ~sync2_reg[SY_CARRY_N];
  assign tinit_s = ~sync2_reg[SY_TINIT_N];
  assign test_s = sync2_reg[SY_TEST];
  assign par_s = sync2_reg[SY_PAR];
  assign fmt_s = sync2_reg[SY_FMT];
  assign accen_s = ~sync2_reg[SY_ACCEN_N];
  assign poen_s = ~sync2_reg[SY_POEN_N];

  // ==========================================================
  // phase offset, phase accumulator and timer accumulator
  logic [WORD_W-1:0] offset_reg, offset_next;
  logic [PHASE_W-1:0] acc_reg, acc_next;
  logic [PHASE_W-1:0] tinc_reg, tinc_next;
  logic [PHASE_W-1:0] tacc_reg, tacc_next;
  logic timer_carry_out_n_n_reg, timer_carry_out_n_n_next;
  logic [PHASE_W:0] tsum;
  logic fifo_in_ready;
  logic acc_adv;

  // accumulator stalls while the sample buffer is full, so no sample is lost
  assign acc_adv = accen_s && fifo_in_ready;

  always_comb begin
    offset_next = offset_reg;
    // RULE19: offset load gate
    if (poen_s) begin
      // RULE1: programmed phase source
      if (psel_s) begin
        offset_next = PHASE_INPUT;
      // RULE2: psk source, RULE18 eight 45 degree steps
      end else begin
        offset_next = {psk_s, {PSK_ZERO_W{1'b0}}};
      end
    end
    acc_next = acc_reg;
    // RULE3: registered carry joins the sum
    if (acc_adv) begin
      acc_next = acc_reg + FREQ_WORD + {{(PHASE_W-1){1'b0}}, carry_s};
    end
    // RULE4: init loads increment and zeroes feedback
    tinc_next = tinit_s ? TIMER_INCREMENT : tinc_reg;
    tsum = {1'b0, (tinit_s ? PHASE_RESET : tacc_reg)} + {1'b0, tinc_reg};
    tacc_next = tsum[PHASE_W-1:0];
    // RULE11: carry drives the output low
    timer_carry_out_n_n_next = ~tsum[PHASE_W];
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      offset_reg <= WORD_RESET;
      acc_reg <= PHASE_RESET;
      tinc_reg <= PHASE_RESET;
      tacc_reg <= PHASE_RESET;
      timer_carry_out_n_n_reg <= 1'b1;
    end else begin
      offset_reg <= offset_next;
      acc_reg <= acc_next;
      tinc_reg <= tinc_next;
      tacc_reg <= tacc_next;
      timer_carry_out_n_n_reg <= timer_carry_out_n_n_next;
    end
  end

  // ==========================================================
  // amplitude lookup
  function automatic logic [WORD_W-1:0] quarter_wave(input logic [4:0] idx);
    case (idx)
      5'h00: quarter_wave = 16'h0000;
      5'h01: quarter_wave = 16'h0C8C;
      5'h02: quarter_wave = 16'h18F9;
      5'h03: quarter_wave = 16'h2528;
      5'h04: quarter_wave = 16'h30FB;
      5'h05: quarter_wave = 16'h3C56;
      5'h06: quarter_wave = 16'h471C;
      5'h07: quarter_wave = 16'h5133;
      5'h08: quarter_wave = 16'h5A82;
      5'h09: quarter_wave = 16'h62F1;
      5'h0A: quarter_wave = 16'h6A6D;
      5'h0B: quarter_wave = 16'h70E2;
      5'h0C: quarter_wave = 16'h7641;
      5'h0D: quarter_wave = 16'h7A7C;
      5'h0E: quarter_wave = 16'h7D89;
      5'h0F: quarter_wave = 16'h7F61;
      default: quarter_wave = 16'h7FFF;
    endcase
  endfunction

  function automatic logic [WORD_W-1:0] sine_of(input logic [LUT_PH_W-1:0] ph);
    logic [WORD_W-1:0] mag;
    mag = ph[4] ? quarter_wave(QUARTER_IDX - {1'b0, ph[3:0]}) : quarter_wave({1'b0, ph[3:0]});
    sine_of = ph[5] ? WORD_W'(-mag) : mag;
  endfunction

  logic [LUT_PH_W-1:0] lut_phase;
  logic [WORD_W-1:0] lut_sin, lut_cos, smp_sin, smp_cos;

  // RULE17: rotating phase plus offset, then table lookup
  assign lut_phase = acc_reg[PHASE_W-1 -: LUT_PH_W] + offset_reg[WORD_W-1 -: LUT_PH_W];
  assign lut_sin = sine_of(lut_phase);
  assign lut_cos = sine_of(LUT_PH_W'(lut_phase + QUARTER_TURN));

  always_comb begin
    // RULE5: test bus carries the top 28 accumulator bits
    if (test_s) begin
      smp_sin = acc_reg[PHASE_W-1 -: WORD_W];
      smp_cos = {acc_reg[WORD_W-1 -: 12], 4'h0};
    // RULE8: offset binary flips the sign bit
    end else begin
      smp_sin = {lut_sin[WORD_W-1] ^ ~fmt_s, lut_sin[WORD_W-2:0]};
      smp_cos = {lut_cos[WORD_W-1] ^ ~fmt_s, lut_cos[WORD_W-2:0]};
    end
  end

  // ==========================================================
  // sample buffer
  logic fifo_out_valid, fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] f_sin, f_cos;

  // RULE16: one sample pair offered per clock
  sample_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RESETN(RESETN),
    .in_valid(1'b1),
    .in_ready(fifo_in_ready),
    .in_data({smp_sin, smp_cos}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign f_sin = fifo_out_data[FIFO_W-1 -: WORD_W];
  assign f_cos = fifo_out_data[WORD_W-1:0];

  // ==========================================================
  // output stage
  ser_state_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [WORD_W-1:0] sword_reg, sword_next, cword_reg, cword_next;
  logic [WORD_W-1:0] sout_reg, sout_next, cout_reg, cout_next;
  logic strobe_n_reg, strobe_n_next;
  logic soe_n_reg, coe_n_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sword_next = sword_reg;
    cword_next = cword_reg;
    sout_next = sout_reg;
    cout_next = cout_reg;
    fifo_out_ready = 1'b0;
    case (state_reg)
      SER_IDLE: begin
        // RULE6: load while enable low, RULE20 framed by controller
        if (!par_s && accen_s && fifo_out_valid) begin
          fifo_out_ready = 1'b1;
          sword_next = f_sin;
          cword_next = f_cos;
          state_next = SER_LOADED;
        end
      end
      SER_LOADED: begin
        if (par_s) begin
          state_next = SER_IDLE;
        end else if (!accen_s) begin
          state_next = SER_SHIFT;
          cnt_next = SHIFT_FIRST;
        end
      end
      SER_SHIFT: begin
        cnt_next = CNT_W'(cnt_reg + 1'b1);
        if (par_s || cnt_reg == SHIFT_LAST) begin
          state_next = SER_IDLE;
        end
      end
      default: begin
        state_next = SER_IDLE;
      end
    endcase
    // RULE7: parallel loads each clock, RULE15 full words
    if (par_s) begin
      fifo_out_ready = 1'b1;
      if (fifo_out_valid) begin
        sout_next = f_sin;
        cout_next = f_cos;
      end
    // RULE13: sine streams, RULE14 cosine streams
    end else if (state_reg == SER_SHIFT) begin
      sout_next = {sword_reg[SHIFT_LAST - cnt_reg], 14'h0000, sword_reg[cnt_reg]};
      cout_next = {cword_reg[SHIFT_LAST - cnt_reg], 14'h0000, cword_reg[cnt_reg]};
    end
    // RULE12: strobe with the first serial bit only
    strobe_n_next = !(state_reg == SER_SHIFT && cnt_reg == SHIFT_FIRST && !par_s);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= SER_IDLE;
      cnt_reg <= SHIFT_FIRST;
      sword_reg <= WORD_RESET;
      cword_reg <= WORD_RESET;
      sout_reg <= WORD_RESET;
      cout_reg <= WORD_RESET;
      strobe_n_reg <= 1'b1;
      soe_n_reg <= 1'b1;
      coe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sword_reg <= sword_next;
      cword_reg <= cword_next;
      sout_reg <= sout_next;
      cout_reg <= cout_next;
      strobe_n_reg <= strobe_n_next;
      // RULE9: sine enable, RULE10 cosine enable, RULE21 per bus
      soe_n_reg <= sync2_reg[SY_OES_N];
      coe_n_reg <= sync2_reg[SY_OEC_N];
    end
  end

  assign SIN_OUT = sout_reg;
  assign COS_OUT = cout_reg;
  assign SIN_OUT_EN_N = soe_n_reg;
  assign COS_OUT_EN_N = coe_n_reg;
  assign TIMER_CARRY_OUT_N = timer_carry_out_n_n_reg;
  assign CONVERTER_WORD_STROBE_N = strobe_n_reg;

  // ==========================================================
  // checks
  chk_offset_programmed: assert property (@(posedge CLK) disable iff (!RESETN) // RULE1
    (poen_s && psel_s) |=> (offset_reg == $past(PHASE_INPUT)))
    else $error("offset not taken from phase input");

  chk_offset_psk: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (poen_s && !psel_s) |=> (offset_reg == {$past(psk_s), 13'h0000}))
    else $error("psk offset wrong");

  chk_offset_hold: assert property (@(posedge CLK) disable iff (!RESETN) // RULE19
    !poen_s |=> $stable(offset_reg))
    else $error("offset changed without load enable");

  chk_accum_carry: assert property (@(posedge CLK) disable iff (!RESETN) // RULE3
    acc_adv |=> (acc_reg == PHASE_W'($past(acc_reg) + $past(FREQ_WORD) + $past(carry_s))))
    else $error("accumulator sum wrong");

  chk_timer_init: assert property (@(posedge CLK) disable iff (!RESETN) // RULE4
    tinit_s |=> (tinc_reg == $past(TIMER_INCREMENT)) && (tacc_reg == $past(tinc_reg)))
    else $error("timer init not applied");

  chk_timer_carry: assert property (@(posedge CLK) disable iff (!RESETN) // RULE11
    tsum[PHASE_W] |=> !TIMER_CARRY_OUT_N)
    else $error("timer carry not shown");

  chk_parallel_load: assert property (@(posedge CLK) disable iff (!RESETN) // RULE7
    (par_s && fifo_out_valid) |=> (SIN_OUT == $past(f_sin)) && (COS_OUT == $past(f_cos)))
    else $error("parallel word not loaded");

  chk_strobe_parallel: assert property (@(posedge CLK) disable iff (!RESETN) // RULE12
    par_s |=> CONVERTER_WORD_STROBE_N)
    else $error("strobe active in parallel mode");

  chk_serial_sine: assert property (@(posedge CLK) disable iff (!RESETN) // RULE13
    (state_reg == SER_SHIFT && !par_s && cnt_reg == SHIFT_FIRST)
    |=> (SIN_OUT[15] == sword_reg[15]) && (SIN_OUT[0] == sword_reg[0]) && !CONVERTER_WORD_STROBE_N
    ##1 (SIN_OUT[15] == sword_reg[14]) && (SIN_OUT[0] == sword_reg[1]))
    else $error("serial sine stream order wrong");

  chk_serial_cos: assert property (@(posedge CLK) disable iff (!RESETN) // RULE14
    (state_reg == SER_SHIFT && !par_s && cnt_reg == SHIFT_LAST)
    |=> (COS_OUT[15] == cword_reg[0]) && (COS_OUT[0] == cword_reg[15]))
    else $error("serial cosine last bit wrong");

  chk_sine_enable: assert property (@(posedge CLK) disable iff (!RESETN) // RULE9
    ##1 (SIN_OUT_EN_N == $past(sync2_reg[SY_OES_N])))
    else $error("sine enable not following pin");

  chk_cos_enable: assert property (@(posedge CLK) disable iff (!RESETN) // RULE10
    ##1 (COS_OUT_EN_N == $past(sync2_reg[SY_OEC_N])))
    else $error("cosine enable not following pin");
endmodule

// ==== shared/nco_ctrl_pkg.sv ====
package nco_ctrl_pkg;
  // ==========================================================
  // widths
  localparam int WORD_W = 16;
  localparam int PHASE_W = 32;
  localparam int PSK_W = 3;
  localparam int PSK_ZERO_W = 13;
  localparam int LUT_PH_W = 6;
  localparam int FIFO_W = 2 * WORD_W;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAX_SAMPLE_RATE_MHZ = 33;
  localparam logic [CNT_W-1:0] SHIFT_LAST = 4'hF;
  localparam logic [CNT_W-1:0] SHIFT_FIRST = 4'h0;

  // ==========================================================
  // synchroniser bit positions
  localparam int SY_PSEL = 0;
  localparam int SY_PSK_LO = 1;
  localparam int SY_CARRY_N = 4;
  localparam int SY_TINIT_N = 5;
  localparam int SY_TEST = 6;
  localparam int SY_PAR = 7;
  localparam int SY_FMT = 8;
  localparam int SY_OES_N = 9;
  localparam int SY_OEC_N = 10;
  localparam int SY_ACCEN_N = 11;
  localparam int SY_POEN_N = 12;
  localparam int SYNC_W = 13;
  // active-low pins idle high, everything else idles low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h1E30;

  // ==========================================================
  // reset values and lookup quarter-turn constants
  localparam logic [PHASE_W-1:0] PHASE_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [LUT_PH_W-1:0] QUARTER_TURN = 6'h10;
  localparam logic [4:0] QUARTER_IDX = 5'h10;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_LOADED = 3'b010,
    SER_SHIFT = 3'b100
  } ser_state_type;
endpackage

// ==== hw/sample_fifo.sv ====
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic push, pop;

  // depth must be a power of two: pointers wrap by overflow
  assign in_ready = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = AW'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = AW'(rd_ptr_reg + 1'b1);
    end
    count_next = CW'(count_reg + CW'(push) - CW'(pop));
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end
endmodule

// ==== verif/dac_serial_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// serial receiver standing in for the sine and cosine converters
module dac_serial_model (
  input wire logic clk,
  input wire logic [nco_ctrl_pkg::WORD_W-1:0] sin_data,
  input wire logic [nco_ctrl_pkg::WORD_W-1:0] cos_data,
  input wire logic strobe_n,
  output logic [nco_ctrl_pkg::WORD_W-1:0] sin_msb_word,
  output logic [nco_ctrl_pkg::WORD_W-1:0] sin_lsb_word,
  output logic [nco_ctrl_pkg::WORD_W-1:0] cos_msb_word,
  output logic [nco_ctrl_pkg::WORD_W-1:0] cos_lsb_word,
  output logic word_done
);
  import nco_ctrl_pkg::*;
  int bit_cnt = 0;
  // a strobe inside a word restarts capture, as a converter would resync
  always @(posedge clk) begin
    word_done <= 1'b0;
    if (!strobe_n || (bit_cnt > 0 && bit_cnt < WORD_W)) begin
      sin_msb_word <= {sin_msb_word[WORD_W-2:0], sin_data[WORD_W-1]};
      sin_lsb_word <= {sin_data[0], sin_lsb_word[WORD_W-1:1]};
      cos_msb_word <= {cos_msb_word[WORD_W-2:0], cos_data[WORD_W-1]};
      cos_lsb_word <= {cos_data[0], cos_lsb_word[WORD_W-1:1]};
      bit_cnt <= strobe_n ? bit_cnt + 1 : 1;
      word_done <= strobe_n && (bit_cnt == WORD_W - 1);
    end else begin
      bit_cnt <= 0;
    end
  end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  import nco_ctrl_pkg::*;
  logic CLK, RESETN, PHASE_SOURCE_SELECT, PHASE_CARRY_IN_N, TIMER_ACCUM_INIT_N;
  logic TEST_SELECT, OUTPUT_PARALLEL_NOT_SERIAL, OUTPUT_FORMAT_SELECT;
  logic SINE_OUTPUT_ENABLE_N, COSINE_OUTPUT_ENABLE_N;
  logic PHASE_ACCUM_LOAD_EN_N, PHASE_OFFSET_LOAD_EN_N;
  logic [PSK_W-1:0] PSK_LEVEL_INPUTS;
  logic [WORD_W-1:0] PHASE_INPUT, SIN_OUT, COS_OUT, sin_msb, sin_lsb, cos_msb, cos_lsb;
  logic [PHASE_W-1:0] FREQ_WORD, TIMER_INCREMENT;
  logic SIN_OUT_EN_N, COS_OUT_EN_N, TIMER_CARRY_OUT_N, CONVERTER_WORD_STROBE_N;
  logic word_done;
  int error_cnt = 0;
  int n_checks = 0;

  nco_mode_and_output_control nco_mode_and_output_control_i (
    .CLK, .RESETN, .PHASE_SOURCE_SELECT, .PSK_LEVEL_INPUTS, .PHASE_CARRY_IN_N,
    .TIMER_ACCUM_INIT_N, .TEST_SELECT, .OUTPUT_PARALLEL_NOT_SERIAL, .OUTPUT_FORMAT_SELECT,
    .SINE_OUTPUT_ENABLE_N, .COSINE_OUTPUT_ENABLE_N, .PHASE_ACCUM_LOAD_EN_N,
    .PHASE_OFFSET_LOAD_EN_N, .PHASE_INPUT, .FREQ_WORD, .TIMER_INCREMENT, .SIN_OUT,
    .SIN_OUT_EN_N, .COS_OUT, .COS_OUT_EN_N, .TIMER_CARRY_OUT_N, .CONVERTER_WORD_STROBE_N);
  dac_serial_model dac_serial_model_i (.clk(CLK), .sin_data(SIN_OUT), .cos_data(COS_OUT),
    .strobe_n(CONVERTER_WORD_STROBE_N), .sin_msb_word(sin_msb), .sin_lsb_word(sin_lsb),
    .cos_msb_word(cos_msb), .cos_lsb_word(cos_lsb), .word_done(word_done));

  // ==========================================================
  // helpers
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the sample fifo adds latency, so settle well past it before sampling
  task automatic grab(output logic [WORD_W-1:0] s, output logic [WORD_W-1:0] c);
    cyc(20);
    s = SIN_OUT;
    c = COS_OUT;
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_enables();
    SINE_OUTPUT_ENABLE_N = 1'b0;
    cyc(8);
    check({SIN_OUT_EN_N, COS_OUT_EN_N}, 2'b01);
    SINE_OUTPUT_ENABLE_N = 1'b1;
    COSINE_OUTPUT_ENABLE_N = 1'b0;
    cyc(8);
    check({SIN_OUT_EN_N, COS_OUT_EN_N}, 2'b10);
    SINE_OUTPUT_ENABLE_N = 1'b0;
  endtask
  task automatic test_offset();
    logic [WORD_W-1:0] s0, c0, s1, c1, cz;
    for (int k = 0; k < 8; k++) begin
      PHASE_SOURCE_SELECT = 1'b1;
      PHASE_INPUT = {k[2:0], 13'h0000};
      grab(s0, c0);
      PHASE_SOURCE_SELECT = 1'b0;
      PSK_LEVEL_INPUTS = k[2:0];
      PHASE_INPUT = 16'h1FFF;
      grab(s1, c1);
      check({s1, c1}, {s0, c0});
      if (k == 0) cz = c1;
      if (k == 2) check(s1, cz);
    end
    PHASE_OFFSET_LOAD_EN_N = 1'b1;
    PSK_LEVEL_INPUTS = 3'h3;
    grab(s0, c0);
    check({s0, c0}, {s1, c1});
    PHASE_OFFSET_LOAD_EN_N = 1'b0;
  endtask
  task automatic test_format();
    logic [WORD_W-1:0] s0, c0, s1, c1;
    int low;
    grab(s0, c0);
    OUTPUT_FORMAT_SELECT = 1'b0;
    grab(s1, c1);
    check({s1, c1}, {s0 ^ 16'h8000, c0 ^ 16'h8000});
    low = 0;
    repeat (16) begin
      cyc(1);
      if (CONVERTER_WORD_STROBE_N !== 1'b1) low++;
    end
    check(low, 0);
    OUTPUT_FORMAT_SELECT = 1'b1;
  endtask
  task automatic test_serial();
    logic [WORD_W-1:0] s0, c0;
    int n, low;
    PHASE_SOURCE_SELECT = 1'b1;
    PHASE_INPUT = 16'h2000;
    grab(s0, c0);
    PHASE_ACCUM_LOAD_EN_N = 1'b1;
    OUTPUT_PARALLEL_NOT_SERIAL = 1'b0;
    cyc(20);
    // enable low frames the load, its rise starts shifting
    PHASE_ACCUM_LOAD_EN_N = 1'b0;
    cyc(8);
    PHASE_ACCUM_LOAD_EN_N = 1'b1;
    n = 0;
    low = 0;
    while (word_done !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
      if (CONVERTER_WORD_STROBE_N === 1'b0) low++;
    end
    check(n < 60, 1'b1);
    check({sin_msb, cos_msb}, {s0, c0});
    check({sin_lsb, cos_lsb}, {s0, c0});
    check(low, 1);
    OUTPUT_PARALLEL_NOT_SERIAL = 1'b1;
    PHASE_ACCUM_LOAD_EN_N = 1'b0;
  endtask
  task automatic test_test_mode();
    logic [WORD_W-1:0] s0;
    TEST_SELECT = 1'b1;
    FREQ_WORD = 32'h0000FFFF;
    PHASE_CARRY_IN_N = 1'b0;
    cyc(20);
    repeat (8) begin
      s0 = SIN_OUT;
      cyc(1);
      check(16'(SIN_OUT - s0), 16'h0001);
      check(COS_OUT[3:0], 4'h0);
    end
    PHASE_CARRY_IN_N = 1'b1;
    FREQ_WORD = 32'h00000000;
    cyc(20);
    s0 = SIN_OUT;
    cyc(8);
    check(SIN_OUT, s0);
    TEST_SELECT = 1'b0;
  endtask
  task automatic test_timer();
    int low;
    TIMER_INCREMENT = 32'h80000000;
    TIMER_ACCUM_INIT_N = 1'b0;
    cyc(10);
    low = 0;
    repeat (20) begin
      cyc(1);
      if (TIMER_CARRY_OUT_N === 1'b0) low++;
    end
    check(low, 0);
    TIMER_ACCUM_INIT_N = 1'b1;
    cyc(10);
    low = 0;
    repeat (40) begin
      cyc(1);
      if (TIMER_CARRY_OUT_N === 1'b0) low++;
    end
    check(low, 20);
  endtask
  task automatic test_fifo();
    logic [WORD_W-1:0] s0;
    int low;
    TEST_SELECT = 1'b1;
    FREQ_WORD = 32'h00010000;
    cyc(20);
    // word parked while enable stays low: buffer fills, accumulator must stall
    OUTPUT_PARALLEL_NOT_SERIAL = 1'b0;
    cyc(4);
    s0 = SIN_OUT;
    low = 0;
    repeat (26) begin
      cyc(1);
      if (CONVERTER_WORD_STROBE_N !== 1'b1) low++;
    end
    check(low, 0);
    check(SIN_OUT, s0);
    // draining the full buffer must show no lost sample at the stall boundary
    OUTPUT_PARALLEL_NOT_SERIAL = 1'b1;
    cyc(4);
    repeat (12) begin
      s0 = SIN_OUT;
      cyc(1);
      check(16'(SIN_OUT - s0), 16'h0001);
      check(COS_OUT[3:0], 4'h0);
    end
    TEST_SELECT = 1'b0;
    FREQ_WORD = 32'h00000000;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    RESETN = 1'b0;
    PHASE_SOURCE_SELECT = 1'b1;
    PSK_LEVEL_INPUTS = 3'h0;
    PHASE_CARRY_IN_N = 1'b1;
    TIMER_ACCUM_INIT_N = 1'b1;
    TEST_SELECT = 1'b0;
    OUTPUT_PARALLEL_NOT_SERIAL = 1'b1;
    OUTPUT_FORMAT_SELECT = 1'b1;
    SINE_OUTPUT_ENABLE_N = 1'b1;
    COSINE_OUTPUT_ENABLE_N = 1'b1;
    PHASE_ACCUM_LOAD_EN_N = 1'b0;
    PHASE_OFFSET_LOAD_EN_N = 1'b0;
    PHASE_INPUT = 16'h0000;
    FREQ_WORD = 32'h00000000;
    TIMER_INCREMENT = 32'h00000000;
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    check({SIN_OUT, COS_OUT}, 32'h00000000);
    check({SIN_OUT_EN_N, COS_OUT_EN_N, TIMER_CARRY_OUT_N, CONVERTER_WORD_STROBE_N}, 4'hF);
    RESETN = 1'b1;
    test_enables();
    test_offset();
    test_format();
    test_serial();
    test_test_mode();
    test_timer();
    test_fifo();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
